// >>> pkg/ldo_map.svh
`ifndef LDO_MAP_SVH
`define LDO_MAP_SVH

// ============================================================
// Register indexes (byte address is four times the index)
// ============================================================
`define LDO_IDX_LOCK_CFG     8'h07
`define LDO_IDX_ANA_CFG      8'h08
`define LDO_IDX_PIN_CFG      8'h0F
`define LDO_IDX_IRQ_STAT     8'h10
`define LDO_IDX_IRQ_MASK     8'h11
`define LDO_IDX_LD_STAT      8'h12

// ============================================================
// Reset values
// ============================================================
`define LDO_LOCK_CFG_RST     24'h200844
`define LDO_ANA_CFG_RST      24'h01BFFF
`define LDO_PIN_CFG_RST      24'h000000
`define LDO_IRQ_MASK_RST     3'h0

// ============================================================
// Field positions, lock detector configuration
// ============================================================
`define LDO_WINSEL_LSB       0
`define LDO_WINSEL_MSB       2
`define LDO_TDIV_LSB         5
`define LDO_TDIV_MSB         7
`define LDO_TSPD_LSB         8
`define LDO_TSPD_MSB         9
`define LDO_LD_EN_BIT        11
`define LDO_LD_MODE_BIT      14
`define LDO_TRAIN_BIT        20

// ============================================================
// Field positions, analog enable and pin configuration
// ============================================================
`define LDO_DRV_EN_BIT       5
`define LDO_BIAS_EN_BIT      10
`define LDO_HF_REF_BIT       21
`define LDO_LEVEL_BIT        22
`define LDO_ALWAYS_DRV_BIT   7

// ============================================================
// Interrupt bits
// ============================================================
`define LDO_IRQ_LOCKED_BIT   0
`define LDO_IRQ_LOST_BIT     1
`define LDO_IRQ_TRAINED_BIT  2

// ============================================================
// Timing
// ============================================================
`define LDO_CLK_PERIOD_PS    25000
`define LDO_TRAIN_TIME_NS    1000
`define LDO_TRAIN_CYCLES     ((`LDO_TRAIN_TIME_NS * 1000 + `LDO_CLK_PERIOD_PS - 1) / `LDO_CLK_PERIOD_PS)

`endif

// >>> pkg/ldo_pkg.sv
package ldo_pkg;

  // Lock detector sequencing states.
  typedef enum logic [1:0] {
    LDO_OFF,
    LDO_TRAIN,
    LDO_TRACK
  } ldo_state_t;

  // Decodes the window select into the consecutive count threshold.
  function automatic logic [15:0] ldo_win_count(input logic [2:0] sel);
    case (sel)
      3'h0:    ldo_win_count = 16'h0005;
      3'h1:    ldo_win_count = 16'h0020;
      3'h2:    ldo_win_count = 16'h0060;
      3'h3:    ldo_win_count = 16'h0100;
      3'h4:    ldo_win_count = 16'h0200;
      3'h5:    ldo_win_count = 16'h0800;
      3'h6:    ldo_win_count = 16'h2000;
      default: ldo_win_count = 16'hFFFF;
    endcase
  endfunction : ldo_win_count

  // Manual timer period in clocks, a power of two from divide and speed.
  function automatic logic [15:0] ldo_timer_period(input logic [2:0] div,
                                                   input logic [1:0] spd);
    logic [3:0] sh;
    sh = {1'b0, div} + {1'b0, spd, 1'b0};
    ldo_timer_period = 16'h0001 << sh;
  endfunction : ldo_timer_period

  // Merges written byte lanes into a 24-bit register.
  function automatic logic [23:0] ldo_merge(input logic [23:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [23:0] res;
    res = old;
    if (strb[0]) res[7:0]   = wd[7:0];
    if (strb[1]) res[15:8]  = wd[15:8];
    if (strb[2]) res[23:16] = wd[23:16];
    ldo_merge = res;
  endfunction : ldo_merge

endpackage : ldo_pkg

// >>> rtl/ldo_lock_counter.sv
`timescale 1ns/1ps

module ldo_lock_counter (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,
  input  wire logic        sample_i,
  input  wire logic        in_window_i,
  input  wire logic [15:0] threshold_i,
  output logic             locked_o
);

  logic [15:0] tally_reg;

  // ============================================================
  // Consecutive count tally
  // ============================================================
  // Tally and lock flag; the tally saturates so 65535 stays reachable.
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      tally_reg <= 16'h0000;
      locked_o  <= 1'b0;
    end else if (sample_i) begin
      if (in_window_i) begin
        if (tally_reg + 16'h0001 >= threshold_i) begin
          locked_o <= 1'b1;
        end
        if (tally_reg != 16'hFFFF) begin
          tally_reg <= tally_reg + 16'h0001;
        end
      end else begin
        tally_reg <= 16'h0000;
        locked_o  <= 1'b0;
      end
    end
  end

endmodule : ldo_lock_counter

// >>> rtl/ldo_top.sv
`timescale 1ns/1ps
`include "ldo_map.svh"

module ldo_top
  import ldo_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              MCLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  input  wire logic              CNT_STROBE_I,
  input  wire logic              CNT_IN_WINDOW_I,
  input  wire logic [2:0]        CHIP_ADDR_I,
  input  wire logic              CHIP_ADDR_VALID_I,
  input  wire logic              SDO_ACTIVE_I,
  input  wire logic              SDO_DATA_I,
  input  wire logic              EXT_VCO_I,
  output logic                   LOCK_SERIAL_OUT_PIN_O,
  output logic                   LOCK_SERIAL_OUT_PIN_OE_O,
  output logic                   SDO_LEVEL_3V_O,
  output logic                   PRESCALER_BIAS_EN_O,
  output logic                   HIGH_FREQ_REF_O,
  output logic                   LOCKED_O,
  output logic                   IRQ_O
);

  localparam logic [15:0] TRAIN_CYCLES = 16'(`LDO_TRAIN_CYCLES);

  // ============================================================
  // Declarations
  // ============================================================
  logic [23:0]       lock_cfg_reg;
  logic [23:0]       ana_cfg_reg;
  logic [23:0]       pin_cfg_reg;
  logic [2:0]        irq_stat_reg;
  logic [2:0]        irq_stat_next;
  logic [2:0]        irq_mask_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              do_write;
  logic [5:0]        widx;
  logic [5:0]        ridx;
  logic              wmapped;
  logic [31:0]       rd_value;
  logic              rmapped;
  logic              train_prev_reg;
  logic              train_start;
  ldo_state_t        state_reg;
  logic [15:0]       train_cnt_reg;
  logic [15:0]       timer_cnt_reg;
  logic              tick_pending_reg;
  logic              timer_tick;
  logic              sample_ok;
  logic              manual_mode;
  logic              locked;
  logic              locked_prev_reg;
  logic [2:0]        events;
  logic [2:0]        last_addr_reg;
  logic              drive_pin;

  assign manual_mode = ~lock_cfg_reg[`LDO_LD_MODE_BIT];

  // ============================================================
  // AXI4-Lite write channel
  // ============================================================
  // Address and data are taken independently; the response waits for both.
  assign S_AXI_AWREADY_O = ~aw_full_reg & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = ~w_full_reg & ~S_AXI_BVALID_O;
  assign do_write        = aw_full_reg & w_full_reg & ~S_AXI_BVALID_O;
  assign widx            = awaddr_reg[7:2];

  // Write address and data holding registers.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR_I;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA_I;
        wstrb_reg  <= S_AXI_WSTRB_I;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write decode; unmapped offsets answer with a decode error.
  always_comb begin
    case ({2'b00, widx})
      `LDO_IDX_LOCK_CFG, `LDO_IDX_ANA_CFG, `LDO_IDX_PIN_CFG,
      `LDO_IDX_IRQ_STAT, `LDO_IDX_IRQ_MASK, `LDO_IDX_LD_STAT: wmapped = 1'b1;
      default:                                                wmapped = 1'b0;
    endcase
  end

  // Write response.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= 2'b00;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wmapped ? 2'b00 : 2'b11;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ============================================================
  // Configuration registers
  // ============================================================
  // Register writes; reserved bits of the three 24-bit registers are stored as written and read back, the mask keeps only bits 2:0.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      lock_cfg_reg <= `LDO_LOCK_CFG_RST;
      ana_cfg_reg  <= `LDO_ANA_CFG_RST;
      pin_cfg_reg  <= `LDO_PIN_CFG_RST;
      irq_mask_reg <= `LDO_IRQ_MASK_RST;
    end else if (do_write) begin
      case ({2'b00, widx})
        `LDO_IDX_LOCK_CFG: lock_cfg_reg <= ldo_merge(lock_cfg_reg, wdata_reg, wstrb_reg);
        `LDO_IDX_ANA_CFG:  ana_cfg_reg  <= ldo_merge(ana_cfg_reg, wdata_reg, wstrb_reg);
        `LDO_IDX_PIN_CFG:  pin_cfg_reg  <= ldo_merge(pin_cfg_reg, wdata_reg, wstrb_reg);
        `LDO_IDX_IRQ_MASK: begin
          if (wstrb_reg[0]) irq_mask_reg <= wdata_reg[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // AXI4-Lite read channel
  // ============================================================
  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
  assign ridx            = S_AXI_ARADDR_I[7:2];

  // Read mux; unmapped offsets read zero.
  always_comb begin
    rmapped  = 1'b1;
    rd_value = 32'h00000000;
    case ({2'b00, ridx})
      `LDO_IDX_LOCK_CFG: rd_value = {8'h00, lock_cfg_reg};
      `LDO_IDX_ANA_CFG:  rd_value = {8'h00, ana_cfg_reg};
      `LDO_IDX_PIN_CFG:  rd_value = {8'h00, pin_cfg_reg};
      `LDO_IDX_IRQ_STAT: rd_value = {29'h0, irq_stat_reg};
      `LDO_IDX_IRQ_MASK: rd_value = {29'h0, irq_mask_reg};
      `LDO_IDX_LD_STAT:  rd_value = {28'h0, state_reg == LDO_TRAIN, drive_pin,
                                     state_reg == LDO_TRACK, locked};
      default:           rmapped  = 1'b0;
    endcase
  end

  // Read data come from a register and stand until taken.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h00000000;
      S_AXI_RRESP_O  <= 2'b00;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_value;
      S_AXI_RRESP_O  <= rmapped ? 2'b00 : 2'b11;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ============================================================
  // Lock detector sequencing
  // ============================================================
  // rising edge trigger
  assign train_start = lock_cfg_reg[`LDO_TRAIN_BIT] & ~train_prev_reg;

  // Previous training bit, so a steady level never retriggers.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      train_prev_reg <= 1'b0;
    end else begin
      train_prev_reg <= lock_cfg_reg[`LDO_TRAIN_BIT];
    end
  end

  // State machine; training holds the tally cleared for a fixed time.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      state_reg     <= LDO_OFF;
      train_cnt_reg <= 16'h0000;
    end else if (!lock_cfg_reg[`LDO_LD_EN_BIT]) begin
      state_reg <= LDO_OFF;
    end else begin
      case (state_reg)
        LDO_OFF: begin
          state_reg <= LDO_TRACK;
        end
        LDO_TRAIN: begin
          if (train_cnt_reg == 16'h0001) begin
            state_reg <= LDO_TRACK;
          end
          train_cnt_reg <= train_cnt_reg - 16'h0001;
        end
        LDO_TRACK: begin
          if (train_start) begin
            state_reg     <= LDO_TRAIN;
            train_cnt_reg <= TRAIN_CYCLES;
          end
        end
        default: begin
          state_reg <= LDO_OFF;
        end
      endcase
    end
  end

  // ============================================================
  // Manual mode sampling timer
  // ============================================================
  // timer only in manual mode
  assign timer_tick = manual_mode &&
                      (timer_cnt_reg >= ldo_timer_period(lock_cfg_reg[`LDO_TDIV_MSB:`LDO_TDIV_LSB],
                                                        lock_cfg_reg[`LDO_TSPD_MSB:`LDO_TSPD_LSB])
                                        - 16'h0001);

  // Free-running timer; a shorter period gives faster but noisier decisions.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !manual_mode || timer_tick) begin
      timer_cnt_reg <= 16'h0000;
    end else begin
      timer_cnt_reg <= timer_cnt_reg + 16'h0001;
    end
  end

  // Tick pending flag; a new tick wins over consumption.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !manual_mode) begin
      tick_pending_reg <= 1'b0;
    end else if (timer_tick) begin
      tick_pending_reg <= 1'b1;
    end else if (CNT_STROBE_I) begin
      tick_pending_reg <= 1'b0;
    end
  end

  assign sample_ok = (state_reg == LDO_TRACK) && CNT_STROBE_I &&
                     (!manual_mode || tick_pending_reg);

  ldo_lock_counter u_counter (
    .clk_i       (MCLK_I),
    .rst_i       (SYS_RST_I),
    .clear_i     (state_reg != LDO_TRACK),
    .sample_i    (sample_ok),
    .in_window_i (CNT_IN_WINDOW_I),
    .threshold_i (ldo_win_count(lock_cfg_reg[`LDO_WINSEL_MSB:`LDO_WINSEL_LSB])),
    .locked_o    (locked)
  );

  // ============================================================
  // Interrupts
  // ============================================================
  assign events = {(state_reg == LDO_TRAIN) && (train_cnt_reg == 16'h0001),
                   locked_prev_reg & ~locked,
                   locked & ~locked_prev_reg};

  // Sticky status, write one to clear; an event in the clearing cycle wins.
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (do_write && ({2'b00, widx} == `LDO_IDX_IRQ_STAT) && wstrb_reg[0]) begin
      irq_stat_next = irq_stat_reg & ~wdata_reg[2:0];
    end
    irq_stat_next = irq_stat_next | events;
  end

  // Status register and lock edge history.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      irq_stat_reg    <= 3'h0;
      locked_prev_reg <= 1'b0;
      IRQ_O           <= 1'b0;
    end else begin
      irq_stat_reg    <= irq_stat_next;
      locked_prev_reg <= locked;
      IRQ_O           <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ============================================================
  // Shared lock / serial-out pin
  // ============================================================
  // Most recent chip address seen by the serial port.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      last_addr_reg <= 3'h0;
    end else if (CHIP_ADDR_VALID_I) begin
      last_addr_reg <= CHIP_ADDR_I;
    end
  end

  assign drive_pin = ana_cfg_reg[`LDO_DRV_EN_BIT] &&
                     (pin_cfg_reg[`LDO_ALWAYS_DRV_BIT] || (last_addr_reg == 3'h0));

  // Registered pin and analog controls, so nothing glitches at the pads.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      LOCK_SERIAL_OUT_PIN_O    <= 1'b0;
      LOCK_SERIAL_OUT_PIN_OE_O <= 1'b0;
      SDO_LEVEL_3V_O           <= 1'b0;
      PRESCALER_BIAS_EN_O      <= 1'b0;
      HIGH_FREQ_REF_O          <= 1'b0;
      LOCKED_O                 <= 1'b0;
    end else begin
      LOCK_SERIAL_OUT_PIN_O    <= SDO_ACTIVE_I ? SDO_DATA_I : locked;
      LOCK_SERIAL_OUT_PIN_OE_O <= drive_pin;
      SDO_LEVEL_3V_O           <= ana_cfg_reg[`LDO_LEVEL_BIT];
      PRESCALER_BIAS_EN_O      <= ana_cfg_reg[`LDO_BIAS_EN_BIT] & EXT_VCO_I;
      HIGH_FREQ_REF_O          <= ana_cfg_reg[`LDO_HF_REF_BIT];
      LOCKED_O                 <= locked;
    end
  end

endmodule : ldo_top

// >>> verification/ldo_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Far-side model: count strobes and received chip addresses
// ============================================================
module ldo_host_model (
  input  wire logic  clk_i,
  output logic       strobe_o,
  output logic       win_o,
  output logic [2:0] addr_o,
  output logic       addr_vld_o
);
  // Idle window and address lines show the inverse of their last value, so a stale value never looks valid.
  initial begin
    strobe_o = 1'b0;
    win_o = 1'b0;
    addr_o = 3'h0;
    addr_vld_o = 1'b0;
  end
  // Back-to-back divided-oscillator counts, all inside or all outside the window.
  task automatic pulses(input int n, input logic iw);
    repeat (n) begin
      @(posedge clk_i);
      strobe_o <= 1'b1;
      win_o <= iw;
    end
    @(posedge clk_i);
    strobe_o <= 1'b0;
    win_o <= ~iw;
    repeat (3) @(negedge clk_i);
  endtask : pulses
  // One received chip address.
  task automatic chip(input logic [2:0] a);
    @(posedge clk_i);
    addr_o <= a;
    addr_vld_o <= 1'b1;
    @(posedge clk_i);
    addr_vld_o <= 1'b0;
    addr_o <= ~a;
    repeat (3) @(negedge clk_i);
  endtask : chip
endmodule : ldo_host_model

// >>> verification/ldo_top_checker.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the lock and pin configuration block
// ============================================================
module ldo_top_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              MCLK_I,
  input wire logic              SYS_RST_I,
  input wire logic              S_AXI_AWVALID_I,
  input wire logic              S_AXI_AWREADY_O,
  input wire logic              S_AXI_WVALID_I,
  input wire logic              S_AXI_WREADY_O,
  input wire logic [1:0]        S_AXI_BRESP_O,
  input wire logic              S_AXI_BVALID_O,
  input wire logic              S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic              S_AXI_ARVALID_I,
  input wire logic              S_AXI_ARREADY_O,
  input wire logic [31:0]       S_AXI_RDATA_O,
  input wire logic [1:0]        S_AXI_RRESP_O,
  input wire logic              S_AXI_RVALID_O,
  input wire logic              S_AXI_RREADY_I,
  input wire logic              CNT_STROBE_I,
  input wire logic              CNT_IN_WINDOW_I,
  input wire logic              EXT_VCO_I,
  input wire logic              PRESCALER_BIAS_EN_O,
  input wire logic              LOCKED_O
);
  logic [3:0] run_reg;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Counts consecutive in-window strobes; saturates so a long run cannot wrap.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || (CNT_STROBE_I && !CNT_IN_WINDOW_I)) run_reg <= 4'h0;
    else if (CNT_STROBE_I && run_reg != 4'hF) run_reg <= run_reg + 4'h1;
  end
  sequence s_wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_resp_late;
    !S_AXI_BVALID_O ##1 S_AXI_BVALID_O;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_resp_late)
    else $error("write response not two edges after address and data");
  a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  a_ready_block: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write accepted while response pending");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read data late");
  a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  a_read_decerr: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && !(S_AXI_ARADDR_I[7:2]
    inside {6'h07, 6'h08, 6'h0F, 6'h10, 6'h11, 6'h12}) |=>
    S_AXI_RRESP_O == 2'h3 && S_AXI_RDATA_O == 32'h0) else $error("unmapped read not refused");
  a_bias_gate: assert property (!EXT_VCO_I |=> !PRESCALER_BIAS_EN_O)
    else $error("bias enabled without external oscillator");
  a_lock_count: assert property ($rose(LOCKED_O) |-> run_reg >= 4'h5)
    else $error("lock declared before five in-window counts");
  a_lock_cause: assert property ($rose(LOCKED_O) |-> $past(CNT_STROBE_I && CNT_IN_WINDOW_I, 2))
    else $error("lock rose without an in-window count");
endmodule : ldo_top_checker

// >>> verification/ldo_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ============================================================
// Register-level bench for the lock and pin configuration block
// ============================================================
module ldo_top_tb;
  logic clk = 1'b0, rst = 1'b1, ext_vco = 1'b1;
  logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0, r_data, d;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, oe, lvl3v, bias, hfref, locked, irq;
  logic strobe, win, cvld, pin, sdo_act = 1'b0, sdo_dat = 1'b0;
  logic [2:0]  caddr;
  logic [1:0]  b_resp, r_resp, rr;
  int n_fail = 0, num_checks = 0;
  // 40 MHz clock.
  always #12.5 clk = ~clk;
  ldo_top dut (.MCLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(aw_addr),
    .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_ready), .S_AXI_WDATA_I(w_data),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(w_valid), .S_AXI_WREADY_O(w_ready),
    .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid), .S_AXI_BREADY_I(b_ready),
    .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid), .S_AXI_ARREADY_O(ar_ready),
    .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_valid),
    .S_AXI_RREADY_I(r_ready), .CNT_STROBE_I(strobe), .CNT_IN_WINDOW_I(win),
    .CHIP_ADDR_I(caddr), .CHIP_ADDR_VALID_I(cvld), .SDO_ACTIVE_I(sdo_act),
    .SDO_DATA_I(sdo_dat), .EXT_VCO_I(ext_vco), .LOCK_SERIAL_OUT_PIN_O(pin),
    .LOCK_SERIAL_OUT_PIN_OE_O(oe),
    .SDO_LEVEL_3V_O(lvl3v), .PRESCALER_BIAS_EN_O(bias), .HIGH_FREQ_REF_O(hfref),
    .LOCKED_O(locked), .IRQ_O(irq));
  ldo_host_model host (.clk_i(clk), .strobe_o(strobe), .win_o(win), .addr_o(caddr),
    .addr_vld_o(cvld));
  // Write one word; handshakes are judged on values settled before the edge.
  task automatic wr(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge clk);
    aw_addr <= {idx[5:0], 2'b00};
    w_data <= v;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      a = aw_valid & aw_ready;
      w = w_valid & w_ready;
      b = b_valid;
      r = b_resp;
      @(posedge clk);
      if (a) aw_valid <= 1'b0;
      if (w) w_valid <= 1'b0;
    end
    b_ready <= 1'b0;
    `CHK(r, er)
  endtask : wr
  // Read one word and its response code.
  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] r);
    logic a, g;
    @(posedge clk);
    ar_addr <= {idx[5:0], 2'b00};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    a = 1'b0;
    while (!a) begin
      @(negedge clk);
      a = r_valid;
      g = ar_ready;
      v = r_data;
      r = r_resp;
      @(posedge clk);
      if (g) ar_valid <= 1'b0;
    end
    ar_valid <= 1'b0;
    r_ready <= 1'b0;
  endtask : rd
  // Read and compare data and response.
  task automatic chkrd(input logic [7:0] idx, input logic [31:0] ev, input logic [1:0] er);
    rd(idx, d, rr);
    `CHK(d, ev)
    `CHK(rr, er)
  endtask : chkrd
  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // A hang costs a failure; the tests need well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chkrd(8'h07, 32'h00200844, 2'h0);
    chkrd(8'h08, 32'h0001BFFF, 2'h0);
    chkrd(8'h05, 32'h0, 2'h3);
    `CHK({oe, bias, lvl3v, hfref}, 4'b1100)
    $display("test reset done");
    // Reference above 200 MHz in this run, so the host sets the flag.
    wr(8'h08, 32'h0061BFDF, 2'h0);
    ext_vco <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK({oe, bias, lvl3v, hfref}, 4'b0011)
    wr(8'h05, 32'h0, 2'h3);
    wr(8'h08, 32'h0001BFFF, 2'h0);
    ext_vco <= 1'b1;
    host.chip(3'h3);
    `CHK({oe, bias, hfref}, 3'b010)
    host.chip(3'h0);
    `CHK(oe, 1'b1)
    wr(8'h0F, 32'h80, 2'h0);
    host.chip(3'h5);
    `CHK(oe, 1'b1)
    wr(8'h0F, 32'h0, 2'h0);
    $display("test pin done");
    wr(8'h07, 32'h00200BE0, 2'h0);
    host.pulses(5, 1'b1);
    `CHK(locked, 1'b0)
    wr(8'h07, 32'h00204BE0, 2'h0);
    host.pulses(5, 1'b1);
    `CHK({locked, irq, pin}, 3'b101)
    // Serial data takes the pin over from the lock flag while active.
    @(posedge clk);
    sdo_act <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK(pin, 1'b0)
    @(posedge clk);
    sdo_act <= 1'b0;
    wr(8'h11, 32'h1, 2'h0);
    // The interrupt output is registered, so it follows the mask one edge later.
    @(negedge clk);
    `CHK({irq, pin}, 2'b11)
    wr(8'h10, 32'h1, 2'h0);
    `CHK(irq, 1'b0)
    host.pulses(1, 1'b0);
    `CHK(locked, 1'b0)
    host.pulses(4, 1'b1);
    `CHK(locked, 1'b0)
    host.pulses(1, 1'b1);
    `CHK(locked, 1'b1)
    wr(8'h07, 32'h00204000, 2'h0);
    host.pulses(5, 1'b1);
    `CHK(locked, 1'b0)
    $display("test lock done");
    wr(8'h07, 32'h00204800, 2'h0);
    wr(8'h10, 32'h7, 2'h0);
    // Retrain by writing the trigger low and then high.
    wr(8'h07, 32'h00304800, 2'h0);
    host.pulses(5, 1'b1);
    `CHK(locked, 1'b0)
    repeat (60) @(negedge clk);
    rd(8'h10, d, rr);
    `CHK(d[2], 1'b1)
    wr(8'h10, 32'h4, 2'h0);
    wr(8'h07, 32'h00304800, 2'h0);
    repeat (60) @(negedge clk);
    rd(8'h10, d, rr);
    `CHK(d[2], 1'b0)
    $display("test training done");
    test_done;
  end
endmodule : ldo_top_tb
bind ldo_top ldo_top_checker #(.ADDR_W(ADDR_W)) u_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .CNT_STROBE_I(CNT_STROBE_I), .CNT_IN_WINDOW_I(CNT_IN_WINDOW_I), .EXT_VCO_I(EXT_VCO_I),
  .PRESCALER_BIAS_EN_O(PRESCALER_BIAS_EN_O), .LOCKED_O(LOCKED_O));
